//--- verilog/moei_pkg.sv
// Function
// [R1] Overflow status register is 32-bit, read-only
// [R2] Status register exists only when presence strap set
// [R3] Bit 31 set while any cache flag set
// [R4] Bit 30 set while any bandwidth flag set
// [R5] Bit r set on any overflow in instance r
// [R6] Separate secure and non-secure status copies
// [R7] Error interrupts only when enable bit 0 set
// [R8] Separate secure/non-secure control and address registers
// [R9] No possible errors: control reads zero, ignores writes
// [R10] High address bits 19:0 hold address 51:32
// [R11] Low address bits 1:0 always read zero
// [R12] Address registers exist only when message strap set
// [R13] Message writes enabled: issue write, suppress wire
// [R14] Warm reset clears message write enable
// [R15] Pending bits follow flags within one clock
package moei_pkg;
   localparam int NUM_INSTANCES = 16;
   localparam int NUM_SPACES = 2;
   localparam int SPACE_NS = 0;
   localparam int SPACE_S = 1;
   // Register offsets inside a feature page
   localparam logic [11:0] OFF_ADDR_LOW = 12'h0e0;
   localparam logic [11:0] OFF_ADDR_HIGH = 12'h0e4;
   localparam logic [11:0] OFF_MSI_ATTR = 12'h0ec;
   localparam logic [11:0] OFF_ERR_CTRL = 12'h0f0;
   localparam logic [11:0] OFF_OVERFLOW_STATUS = 12'h8f0;
   // Field positions and widths
   localparam int POS_CACHE_PND = 31;
   localparam int POS_BW_PND = 30;
   localparam int POS_INT_ENABLE = 0;
   localparam int POS_MSI_ENABLE = 0;
   localparam int ADDR_HIGH_W = 20;
   localparam int ADDR_LOW_LSB = 2;
   localparam int MSI_ADDR_W = 52;
   // Reset values
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   localparam logic [ADDR_HIGH_W-1:0] ADDR_HIGH_RST = 20'h0_0000;
   localparam logic [31:ADDR_LOW_LSB] ADDR_LOW_RST = 30'h0000_0000;

   // Overflow flags of one partition space, one bit per resource instance
   typedef struct packed {
      logic [NUM_INSTANCES-1:0] cache_flag;
      logic [NUM_INSTANCES-1:0] bw_flag;
      logic [NUM_INSTANCES-1:0] bw_long_flag;
   } moei_flags_s;

   // Register access request on a feature page
   typedef struct packed {
      logic req;
      logic write;
      logic secure;
      logic [11:0] offset;
      logic [31:0] wdata;
   } moei_req_s;
endpackage

//--- verilog/moei_regs.sv
`timescale 1ns/1ps
module moei_regs
(
   // Clock and warm reset
   input wire logic clk,
   input wire logic rst_n,
   // Straps
   input wire logic overflow_status_present,
   input wire logic error_msi_present,
   input wire logic errors_possible,
   // Register access
   input wire moei_pkg::moei_req_s acc,
   output logic [31:0] rdata,
   output logic rvalid,
   // Monitor overflow flags, index 0 non-secure, 1 secure
   input wire moei_pkg::moei_flags_s flags [moei_pkg::NUM_SPACES],
   // Error sources
   input wire logic [moei_pkg::NUM_SPACES-1:0] err_event,
   input wire logic [moei_pkg::NUM_SPACES-1:0] err_pending,
   // Error signalling
   output logic [moei_pkg::NUM_SPACES-1:0] err_irq,
   output logic msi_valid,
   input wire logic msi_ready,
   output logic [moei_pkg::MSI_ADDR_W-1:0] msi_addr,
   output logic msi_secure
);
   import moei_pkg::*;

   logic [31:0] status_q [NUM_SPACES];
   logic [31:0] status_d [NUM_SPACES];
   logic [NUM_SPACES-1:0] irq_enable_q, irq_enable_d, msi_enable_q, msi_enable_d;
   logic [ADDR_HIGH_W-1:0] addr_h_q [NUM_SPACES];
   logic [ADDR_HIGH_W-1:0] addr_h_d [NUM_SPACES];
   logic [31:ADDR_LOW_LSB] addr_l_q [NUM_SPACES];
   logic [31:ADDR_LOW_LSB] addr_l_d [NUM_SPACES];
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic [NUM_SPACES-1:0] irq_q, irq_d, pend_q, pend_d, use_msi;
   logic msi_valid_q, msi_valid_d, msi_sec_q, msi_sec_d;
   logic [MSI_ADDR_W-1:0] msi_addr_q, msi_addr_d;
   logic sp;

   assign sp = acc.secure;

   // Status summaries, recomputed every cycle from the flags
   always_comb
   begin
      for (int s = 0; s < NUM_SPACES; s++)
      begin
         status_d[s] = READ_ZERO;
         status_d[s][POS_CACHE_PND] = |flags[s].cache_flag; // [R3]
         status_d[s][POS_BW_PND] = |(flags[s].bw_flag | flags[s].bw_long_flag); // [R4]
         status_d[s][NUM_INSTANCES-1:0] = flags[s].cache_flag | flags[s].bw_flag
                                    | flags[s].bw_long_flag; // [R5]
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int s = 0; s < NUM_SPACES; s++)
            status_q[s] <= READ_ZERO;
      end
      else
      begin
         for (int s = 0; s < NUM_SPACES; s++)
            status_q[s] <= status_d[s]; // [R15] [R6]
      end
   end

   // Register writes; each page only touches its own copy
   always_comb
   begin
      irq_enable_d = irq_enable_q;
      msi_enable_d = msi_enable_q;
      for (int s = 0; s < NUM_SPACES; s++)
      begin
         addr_h_d[s] = addr_h_q[s];
         addr_l_d[s] = addr_l_q[s];
      end
      if (acc.req && acc.write)
      begin
         // Status register has no write path at all
         unique case (acc.offset)
            OFF_ERR_CTRL:
               if (errors_possible)
                  irq_enable_d[sp] = acc.wdata[POS_INT_ENABLE]; // [R9] [R8]
            OFF_ADDR_HIGH:
               if (error_msi_present)
                  addr_h_d[sp] = acc.wdata[ADDR_HIGH_W-1:0]; // [R10] [R12]
            OFF_ADDR_LOW:
               if (error_msi_present)
                  addr_l_d[sp] = acc.wdata[31:ADDR_LOW_LSB]; // [R11] [R12]
            OFF_MSI_ATTR:
               if (error_msi_present)
                  msi_enable_d[sp] = acc.wdata[POS_MSI_ENABLE];
            default:
               irq_enable_d = irq_enable_q; // [R1]
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_enable_q <= '0;
         msi_enable_q <= '0; // [R14]
         for (int s = 0; s < NUM_SPACES; s++)
         begin
            addr_h_q[s] <= ADDR_HIGH_RST;
            addr_l_q[s] <= ADDR_LOW_RST;
         end
      end
      else
      begin
         irq_enable_q <= irq_enable_d;
         msi_enable_q <= msi_enable_d;
         for (int s = 0; s < NUM_SPACES; s++)
         begin
            addr_h_q[s] <= addr_h_d[s];
            addr_l_q[s] <= addr_l_d[s];
         end
      end
   end

   // Read answer one cycle after the request; absent registers read zero
   always_comb
   begin
      rdata_d = READ_ZERO;
      rvalid_d = acc.req && !acc.write;
      if (acc.req && !acc.write)
      begin
         unique case (acc.offset)
            OFF_OVERFLOW_STATUS:
               if (overflow_status_present)
                  rdata_d = status_q[sp]; // [R2] [R6]
            OFF_ERR_CTRL:
               if (errors_possible)
                  rdata_d[POS_INT_ENABLE] = irq_enable_q[sp]; // [R9]
            OFF_ADDR_HIGH:
               if (error_msi_present)
                  rdata_d[ADDR_HIGH_W-1:0] = addr_h_q[sp]; // [R10] [R12]
            OFF_ADDR_LOW:
               if (error_msi_present)
                  rdata_d[31:ADDR_LOW_LSB] = addr_l_q[sp]; // [R11] [R12]
            OFF_MSI_ATTR:
               if (error_msi_present)
                  rdata_d[POS_MSI_ENABLE] = msi_enable_q[sp];
            default:
               rdata_d = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= READ_ZERO;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Error signalling per space: wire while message writes are off, message write for events while on
   always_comb
   begin
      pend_d = pend_q;
      msi_valid_d = msi_valid_q;
      msi_sec_d = msi_sec_q;
      msi_addr_d = msi_addr_q;
      for (int s = 0; s < NUM_SPACES; s++)
      begin
         use_msi[s] = msi_enable_q[s] && error_msi_present;
         irq_d[s] = irq_enable_q[s] && !use_msi[s] && err_pending[s]; // [R7] [R13]
      end
      if (msi_valid_q && msi_ready)
         msi_valid_d = 1'b0;
      // One write in flight; secure space served first when both wait
      if (!msi_valid_q)
      begin
         for (int s = 0; s < NUM_SPACES; s++)
         begin
            if (pend_q[s])
            begin
               msi_valid_d = 1'b1; // [R13]
               msi_sec_d = (s == SPACE_S);
               msi_addr_d = {addr_h_q[s], addr_l_q[s], 2'b00}; // [R11]
            end
         end
         if (pend_q[SPACE_S])
            pend_d[SPACE_S] = 1'b0;
         else
            pend_d[SPACE_NS] = 1'b0;
      end
      // A new event wins over the clear in the same cycle
      for (int s = 0; s < NUM_SPACES; s++)
         if (err_event[s] && irq_enable_q[s] && use_msi[s])
            pend_d[s] = 1'b1; // [R7] [R13]
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_q <= '0;
         irq_q <= '0;
         msi_valid_q <= 1'b0;
         msi_sec_q <= 1'b0;
         msi_addr_q <= '0;
      end
      else
      begin
         pend_q <= pend_d;
         irq_q <= irq_d;
         msi_valid_q <= msi_valid_d;
         msi_sec_q <= msi_sec_d;
         msi_addr_q <= msi_addr_d;
      end
   end

   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign err_irq = irq_q;
   assign msi_valid = msi_valid_q;
   assign msi_addr = msi_addr_q;
   assign msi_secure = msi_sec_q;

   // Checks; the summary checks skip the first edge after reset, where the
   // registered copy still holds its reset value while the flags may be set
   chk_status_cache: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
      $past(rst_n)
      |-> status_q[SPACE_S][POS_CACHE_PND] == $past(|flags[SPACE_S].cache_flag))
      else $error("cache summary bit does not follow flags");
   chk_status_bw: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      $past(rst_n)
      |-> status_q[SPACE_NS][POS_BW_PND] == $past(|(flags[SPACE_NS].bw_flag
                                                  | flags[SPACE_NS].bw_long_flag)))
      else $error("bandwidth summary bit does not follow flags");
   chk_status_ris: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      $past(rst_n)
      |-> status_q[SPACE_NS][NUM_INSTANCES-1:0] == $past(flags[SPACE_NS].cache_flag
         | flags[SPACE_NS].bw_flag | flags[SPACE_NS].bw_long_flag))
      else $error("instance pending bits wrong");
   chk_status_absent: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      (acc.req && !acc.write && acc.offset == OFF_OVERFLOW_STATUS && !overflow_status_present)
      |=> rvalid && rdata == READ_ZERO)
      else $error("absent status register not read as zero");
   // Launched address must be the low register of its own space, word aligned
   chk_addr_low_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
      $rose(msi_valid) |-> msi_addr[ADDR_LOW_LSB-1:0] == '0
         && msi_addr[31:ADDR_LOW_LSB] == (msi_secure ? $past(addr_l_q[SPACE_S])
                                                     : $past(addr_l_q[SPACE_NS])))
      else $error("message address not word aligned");
   chk_high_reserved: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      (acc.req && !acc.write && acc.offset == OFF_ADDR_HIGH) |=> rdata[31:ADDR_HIGH_W] == '0)
      else $error("high address reserved bits not zero");
   chk_irq_enable: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      (err_irq & ~$past(irq_enable_q & err_pending)) == '0)
      else $error("error interrupt without enable");
   chk_msi_suppress: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
      $past(use_msi[SPACE_NS]) |-> !err_irq[SPACE_NS])
      else $error("wire interrupt raised while message writes enabled");
   chk_msi_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
      (msi_valid && !msi_ready) |=> msi_valid && $stable(msi_addr))
      else $error("message write dropped before acceptance");
   chk_ctrl_raz: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      !errors_possible |-> irq_enable_q == $past(irq_enable_q))
      else $error("control register written without possible errors");
endmodule

//--- verif/moei_msi_sink.sv
`timescale 1ns/1ps
// Stand-in for the interrupt controller that takes message writes
module moei_msi_sink
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Message write channel
   input wire logic msi_valid,
   output logic msi_ready,
   // Cycles to stall each write, so a held request is exercised
   input wire logic [1:0] stall
);
   logic [1:0] wait_q;
   logic [1:0] wait_d;
   // Count stalled cycles of the pending write
   always_comb
   begin
      wait_d = (msi_valid && !msi_ready) ? wait_q + 2'h1 : 2'h0;
   end
   // Accept once the stall has run out
   assign msi_ready = msi_valid && (wait_q >= stall);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wait_q <= 2'h0;
      else
         wait_q <= wait_d;
   end
endmodule

//--- verif/mon_overflow_err_irq_regs_tb.sv
`timescale 1ns/1ps
module mon_overflow_err_irq_regs_tb;
   import moei_pkg::*;
   logic clk, rst_n, st_en, msi_en, err_en, rvalid, msi_valid, msi_ready, msi_secure;
   moei_req_s acc;
   moei_flags_s flags [NUM_SPACES];
   logic [31:0] rdata;
   logic [1:0] err_event, err_pending, err_irq, stall;
   logic [51:0] msi_addr;
   int mismatches, checks;
   logic [31:0] rd_q[$];
   logic [52:0] msi_q[$];
   logic [31:0] lo [2];
   logic [31:0] hi [2];
   logic [11:0] offs [5] = '{OFF_ADDR_LOW, OFF_ADDR_HIGH, OFF_MSI_ATTR, OFF_ERR_CTRL, 12'h100};

   moei_regs DUT (.clk(clk), .rst_n(rst_n), .overflow_status_present(st_en),
      .error_msi_present(msi_en), .errors_possible(err_en), .acc(acc), .rdata(rdata),
      .rvalid(rvalid), .flags(flags), .err_event(err_event), .err_pending(err_pending),
      .err_irq(err_irq), .msi_valid(msi_valid), .msi_ready(msi_ready),
      .msi_addr(msi_addr), .msi_secure(msi_secure));
   moei_msi_sink sink (.clk(clk), .rst_n(rst_n), .msi_valid(msi_valid),
      .msi_ready(msi_ready), .stall(stall));

   // Clock at 200 MHz
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task check(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task complete_run;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One request per two cycles keeps req changes off the sampling edge
   task rw(input logic w, input logic s, input logic [11:0] off, input logic [31:0] d);
      cyc(1);
      acc = '{1'b1, w, s, off, d};
      cyc(1);
      acc.req = 1'b0;
   endtask

   task rd(input logic s, input logic [11:0] off, input logic [31:0] exp);
      rd_q.push_back(exp);
      rw(1'b0, s, off, 32'h0);
   endtask

   // Bounded wait for every noted message write to be taken
   task drain;
      int n;
      n = 0;
      while (msi_q.size() > 0 && n < 20)
      begin
         cyc(1);
         n++;
      end
      if (msi_q.size() > 0)
      begin
         mismatches++;
         complete_run();
      end
   endtask

   function automatic logic [31:0] st(moei_flags_s f);
      logic [15:0] any;
      any = f.cache_flag | f.bw_flag | f.bw_long_flag;
      return {|f.cache_flag, |(f.bw_flag | f.bw_long_flag), 14'h0, any};
   endfunction

   task pulse(input logic [1:0] e);
      err_event = e;
      cyc(1);
      err_event = 2'b00;
   endtask

   // Results are matched against the oldest note as they appear
   always @(negedge clk)
   begin
      if (rvalid === 1'b1)
         check(rdata, rd_q.size() > 0 ? rd_q.pop_front() : 32'hdead_beef);
      if (msi_valid === 1'b1 && msi_ready === 1'b1)
         check({msi_secure, msi_addr}, msi_q.size() > 0 ? msi_q.pop_front() : '1);
   end

   initial
   begin
      rst_n = 1'b0;
      {st_en, msi_en, err_en} = 3'b111;
      acc = '0;
      flags = '{default: '0};
      {err_event, err_pending, stall} = 6'h00;
      void'($urandom(32'hfd06));
      cyc(2);
      rst_n = 1'b1;
      foreach (offs[i]) for (int s = 0; s < 2; s++) rd(1'(s), offs[i], 32'h0);
      $display("reset values done");
      for (int s = 0; s < 2; s++)
      begin
         lo[s] = $urandom();
         hi[s] = $urandom();
         rw(1'b1, 1'(s), OFF_ADDR_LOW, lo[s]);
         rw(1'b1, 1'(s), OFF_ADDR_HIGH, hi[s]);
      end
      for (int s = 0; s < 2; s++)
      begin
         rd(1'(s), OFF_ADDR_LOW, lo[s] & 32'hffff_fffc);
         rd(1'(s), OFF_ADDR_HIGH, hi[s] & 32'h000f_ffff);
      end
      $display("address registers done");
      // Random flags, then all cleared; a status write must change nothing
      for (int k = 0; k < 5; k++)
      begin
         for (int s = 0; s < 2; s++)
            flags[s] = k == 4 ? '0 : moei_flags_s'(48'({$urandom(), $urandom()} >> (k * 12)));
         rw(1'b1, k[0], OFF_OVERFLOW_STATUS, 32'hffff_ffff);
         rd(1'b0, OFF_OVERFLOW_STATUS, st(flags[0]));
         rd(1'b1, OFF_OVERFLOW_STATUS, st(flags[1]));
      end
      $display("status done");
      err_pending = 2'b11;
      rw(1'b1, 1'b0, OFF_ERR_CTRL, 32'h1);
      cyc(2);
      check(err_irq, 2'b01);
      rw(1'b1, 1'b0, OFF_MSI_ATTR, 32'h1);
      cyc(2);
      check(err_irq, 2'b00);
      msi_q.push_back({1'b0, hi[0][19:0], lo[0][31:2], 2'b00});
      pulse(2'b01);
      drain();
      // Disabled secure space must stay silent, then a stalled write
      rw(1'b1, 1'b1, OFF_MSI_ATTR, 32'h1);
      pulse(2'b10);
      cyc(4);
      rw(1'b1, 1'b1, OFF_ERR_CTRL, 32'h1);
      stall = 2'h2;
      msi_q.push_back({1'b1, hi[1][19:0], lo[1][31:2], 2'b00});
      pulse(2'b10);
      drain();
      check(err_irq, 2'b00);
      $display("error signalling done");
      // Absent features after a warm reset
      flags = '{default: '1};
      {st_en, msi_en, err_en} = 3'b000;
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      for (int s = 0; s < 2; s++)
      begin
         rw(1'b1, 1'(s), OFF_ERR_CTRL, 32'h1);
         rw(1'b1, 1'(s), OFF_ADDR_LOW, 32'hffff_ffff);
         rd(1'(s), OFF_OVERFLOW_STATUS, 32'h0);
         rd(1'(s), OFF_ERR_CTRL, 32'h0);
         rd(1'(s), OFF_ADDR_LOW, 32'h0);
      end
      check(err_irq, 2'b00);
      cyc(3);
      check(rd_q.size(), 0);
      $display("absent features done");
      complete_run();
   end
endmodule
